// *** rtl/aep_pkg.sv ***
package aep_pkg;

  // Frame geometry
  localparam int NB     = 40;
  localparam int TAPS   = 12;
  localparam int DECIM  = 6;
  localparam int HOP_IN = 32;
  localparam int FRAME_HOP_SAMPLES = 192;

  // Word formats
  localparam int IW = 24;
  localparam int SW = 32;
  localparam int EW = 48;
  localparam int CW = 18;
  localparam int FB = 23;
  localparam int QB = 16;

  // Times and rates
  localparam real FS_HZ      = 48000.0;
  localparam real T_SLOPE_S  = 0.100;
  localparam real T_FM_MIN_S = 0.004;
  localparam real T_FM_100_S = 0.020;
  localparam real BARK_REF_HZ = 650.0;
  localparam real LO_SLOPE_DB = 31.0;

  // Slope floor and log-to-slope factor in Q8.8 dB per Bark, then the power floor
  localparam logic signed [31:0] MIN_SLOPE_Q8 = 32'sh00000400;
  localparam logic signed [31:0] LG_TO_SLOPE_Q8 = 32'($rtoi(2.0 * $log10(2.0) * 256.0 + 0.5));
  localparam logic [EW-1:0] P_FLOOR = 48'h000000000001;

  localparam real FC_HZ [NB] = '{
    50.00, 116.19, 183.57, 252.82, 324.64, 399.79, 479.01, 563.11, 652.97, 749.48,
    853.65, 966.52, 1089.25, 1223.10, 1369.43, 1529.73, 1705.64, 1898.95, 2111.64, 2345.88,
    2604.05, 2888.79, 3203.01, 3549.90, 3933.02, 4356.27, 4823.97, 5340.88, 5912.30, 6544.03,
    7242.54, 8014.95, 8869.13, 9813.82, 10858.63, 12014.24, 13292.44, 14706.26, 16270.13, 18000.02};

  typedef enum logic [2:0] {ST_LOAD, ST_LEVEL, ST_SLOPE, ST_UP, ST_DOWN, ST_BAND} aep_phase_t;

  typedef logic [NB-1:0][CW-1:0]   aep_cvec_t;
  typedef logic [NB-1:0][15:0]     aep_kvec_t;
  typedef logic [NB-1:0][EW-1:0]   aep_evec_t;
  typedef logic [NB-1:0][SW-1:0]   aep_svec_t;
  typedef logic [TAPS-1:0][CW-1:0] aep_tvec_t;

  typedef struct packed {
    logic signed [IW-1:0] re;
    logic signed [IW-1:0] im;
  } aep_band_in_t;

  typedef struct packed {
    logic [15:0]   index;
    logic [5:0]    band;
    logic [EW-1:0] unsmeared;
    logic [EW-1:0] excitation;
  } aep_pattern_t;

  function automatic logic [CW-1:0] q16(input real x);
    return CW'($rtoi(x * 65536.0 + 0.5));
  endfunction

  function automatic real bark(input real f);
    return 7.0 * $asinh(f / BARK_REF_HZ);
  endfunction

  localparam real BARK_STEP = (bark(FC_HZ[NB-1]) - bark(FC_HZ[0])) / 39.0;

  // Log2 of the per-step fraction for one dB per Bark
  localparam logic [31:0] KD_Q16 = 32'($rtoi(BARK_STEP / 20.0 * $ln(10.0) / $ln(2.0) * 65536.0 + 0.5));
  localparam logic [CW-1:0] LO_GAIN = q16($pow(0.1, LO_SLOPE_DB * BARK_STEP / 20.0));
  localparam real CU_A = $exp(-HOP_IN / (FS_HZ * T_SLOPE_S));
  localparam logic [CW-1:0] CU_KEEP = q16(CU_A);
  localparam logic [CW-1:0] CU_NEW  = q16(1.0 - CU_A);

  function automatic aep_cvec_t gen_ear_gain();
    aep_cvec_t v;
    real f;
    real w;
    for (int k = 0; k < NB; k++) begin
      f = FC_HZ[k] / 1000.0;
      w = -0.6 * 3.64 * $pow(f, -0.8) + 6.5 * $exp(-0.6 * (f - 3.3) * (f - 3.3)) - 0.001 * $pow(f, 3.6);
      v[k] = q16($pow(10.0, w / 20.0));
    end
    return v;
  endfunction

  function automatic aep_kvec_t gen_knee();
    aep_kvec_t v;
    for (int k = 0; k < NB; k++) begin
      v[k] = 16'($rtoi((24.0 + 230.0 / FC_HZ[k]) * 256.0 + 0.5));
    end
    return v;
  endfunction

  function automatic aep_evec_t gen_noise();
    aep_evec_t v;
    for (int k = 0; k < NB; k++) begin
      v[k] = EW'($rtoi($pow(10.0, 0.4 * 0.364 * $pow(FC_HZ[k] / 1000.0, -0.8)) * 8388608.0 + 0.5));
    end
    return v;
  endfunction

  function automatic aep_cvec_t gen_fm(input logic keep);
    aep_cvec_t v;
    real tau;
    real a;
    for (int k = 0; k < NB; k++) begin
      tau = T_FM_MIN_S + 100.0 / FC_HZ[k] * (T_FM_100_S - T_FM_MIN_S);
      a = $exp(-FRAME_HOP_SAMPLES / (FS_HZ * tau));
      v[k] = keep ? q16(a) : q16(1.0 - a);
    end
    return v;
  endfunction

  function automatic aep_tvec_t gen_taps();
    aep_tvec_t v;
    real c;
    for (int i = 0; i < TAPS; i++) begin
      c = $cos(3.14159265358979 * (i - 5) / 12.0);
      v[i] = q16(0.9761 / DECIM * c * c);
    end
    return v;
  endfunction

  localparam aep_cvec_t EAR_GAIN = gen_ear_gain();
  localparam aep_kvec_t KNEE     = gen_knee();
  localparam aep_evec_t NOISE    = gen_noise();
  localparam aep_cvec_t FM_KEEP  = gen_fm(1'b1);
  localparam aep_cvec_t FM_NEW   = gen_fm(1'b0);
  localparam aep_tvec_t TAP      = gen_taps();

  // Signed sample times unsigned Q.16 coefficient
  function automatic logic signed [SW-1:0] mulc(input logic signed [SW-1:0] x, input logic [CW-1:0] c);
    logic signed [SW+CW:0] p;
    p = x * $signed({1'b0, c});
    return p[SW+QB-1:QB];
  endfunction

  // Energy times unsigned Q.16 coefficient
  function automatic logic [EW-1:0] mule(input logic [EW-1:0] e, input logic [CW-1:0] c);
    logic [EW+CW-1:0] p;
    p = e * c;
    return p[EW+QB-1:QB];
  endfunction

  // Squared magnitude of a complex pair, kept in Q.23
  function automatic logic [EW-1:0] energy(input logic signed [SW-1:0] re, input logic signed [SW-1:0] im);
    logic signed [95:0] s;
    s = re * re + im * im;
    return s[EW+FB-1:FB];
  endfunction

endpackage

// *** rtl/aep_slope_frac.sv ***
`timescale 1ns/100ps
module aep_slope_frac (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [aep_pkg::EW-1:0]   power,
  input  wire logic [15:0]              knee,
  output logic      [aep_pkg::CW-1:0]   frac
);

  typedef struct packed {
    logic [aep_pkg::CW-1:0] frac;
  } aep_frac_state_t;

  aep_frac_state_t st;
  aep_frac_state_t next_st;

  assign frac = st.frac;

  // Log, slope, then antilog; piecewise-linear both ways to avoid tables
  always_comb begin
    logic [5:0]             msb;
    logic [aep_pkg::EW-1:0] p;
    logic [aep_pkg::EW-1:0] norm;
    logic signed [15:0]     ip;
    logic signed [15:0]     lg;
    logic signed [31:0]     sl;
    logic [63:0]            prod;
    logic [31:0]            x;
    logic [16:0]            mant;
    msb = '0;
    p = '0;
    norm = '0;
    ip = '0;
    lg = '0;
    sl = '0;
    prod = '0;
    x = '0;
    mant = '0;
    next_st = st;
    p = (power < aep_pkg::P_FLOOR) ? aep_pkg::P_FLOOR : power;
    for (int i = 0; i < aep_pkg::EW; i++) begin
      if (p[i]) begin
        msb = 6'(i);
      end
    end
    norm = p << (6'd47 - msb);
    ip = $signed({10'h000, msb}) - 16'sh0017;
    lg = (ip <<< 8) + $signed({8'h00, norm[46:39]});
    sl = $signed({16'h0000, knee}) - ((aep_pkg::LG_TO_SLOPE_Q8 * 32'(lg)) >>> 8);
    if (sl < aep_pkg::MIN_SLOPE_Q8) begin
      sl = aep_pkg::MIN_SLOPE_Q8;
    end
    prod = 64'($unsigned(sl)) * 64'(aep_pkg::KD_Q16);
    x = prod[47:16];
    mant = 17'h10000 - 17'({x[7:0], 7'h00});
    next_st.frac = (x[31:8] > 24'h000010) ? '0 : aep_pkg::CW'(mant >> x[12:8]);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// *** rtl/aep_excitation_pipeline.sv ***
`timescale 1ns/100ps
module aep_excitation_pipeline (
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  input  wire logic                   MEAS_START,
  input  wire logic                   IN_VALID,
  input  aep_pkg::aep_band_in_t       IN_SAMPLE,
  output logic                        IN_READY,
  output logic                        OUT_VALID,
  output aep_pkg::aep_pattern_t       OUT_PATTERN
);

  typedef struct packed {
    aep_pkg::aep_phase_t       state;
    logic                      ready;
    logic [5:0]                k;
    logic [5:0]                j;
    logic [2:0]                ph;
    logic [15:0]               frame;
    logic signed [aep_pkg::SW-1:0] d1;
    logic signed [aep_pkg::SW-1:0] d2;
    aep_pkg::aep_svec_t        wre;
    aep_pkg::aep_svec_t        wim;
    aep_pkg::aep_svec_t        are;
    aep_pkg::aep_svec_t        aim;
    aep_pkg::aep_cvec_t        cu;
    aep_pkg::aep_evec_t        acc_a;
    aep_pkg::aep_evec_t        acc_b;
    aep_pkg::aep_evec_t        fm;
    logic                      out_valid;
    aep_pkg::aep_pattern_t     out;
  } aep_pipe_state_t;

  aep_pipe_state_t        st;
  aep_pipe_state_t        next_st;
  logic [aep_pkg::EW-1:0] lvl_power;
  logic [aep_pkg::CW-1:0] upper_spread_gain;

  assign IN_READY    = st.ready;
  assign OUT_VALID   = st.out_valid;
  assign OUT_PATTERN = st.out;

  // Power of the weighted band feeds the slope unit; its answer lands one cycle later
  assign lvl_power = aep_pkg::energy($signed(st.wre[st.k]), $signed(st.wim[st.k]));

  aep_slope_frac u_slope (
    .clock (CLOCK),
    .rst_n (RST_N),
    .power (lvl_power),
    .knee  (aep_pkg::KNEE[st.k]),
    .frac  (upper_spread_gain)
  );

  // Band-serial sequencer; one frame takes well under the 3200 cycles between frames
  always_comb begin
    logic signed [aep_pkg::SW-1:0] weighted_band_real;
    logic signed [aep_pkg::SW-1:0] weighted_band_imag;
    logic signed [aep_pkg::SW-1:0] n1;
    logic signed [aep_pkg::SW-1:0] n2;
    logic [aep_pkg::EW-1:0]        e0;
    logic [aep_pkg::EW-1:0]        sa;
    logic [aep_pkg::EW-1:0]        sb;
    logic [aep_pkg::EW-1:0]        e2;
    logic [3:0]                    ta;
    logic [3:0]                    tb;
    weighted_band_real = '0;
    weighted_band_imag = '0;
    n1 = '0;
    n2 = '0;
    e0 = '0;
    sa = '0;
    sb = '0;
    e2 = '0;
    ta = '0;
    tb = '0;
    next_st = st;
    next_st.out_valid = 1'b0;
    case (st.state)
      aep_pkg::ST_LOAD: begin
        // Input opens on the second cycle after reset
        if (!st.ready) begin
          next_st.ready = 1'b1;
        end
        if (IN_VALID && st.ready) begin
          weighted_band_real = aep_pkg::mulc(aep_pkg::SW'(IN_SAMPLE.re), aep_pkg::EAR_GAIN[st.k]);
          weighted_band_imag = aep_pkg::mulc(aep_pkg::SW'(IN_SAMPLE.im), aep_pkg::EAR_GAIN[st.k]);
          next_st.wre[st.k] = weighted_band_real;
          next_st.wim[st.k] = weighted_band_imag;
          next_st.are[st.k] = weighted_band_real;
          next_st.aim[st.k] = weighted_band_imag;
          if (st.k == 6'd39) begin
            next_st.k = '0;
            next_st.ready = 1'b0;
            next_st.state = aep_pkg::ST_LEVEL;
          end else begin
            next_st.k = st.k + 6'd1;
          end
        end
      end
      aep_pkg::ST_LEVEL: begin
        next_st.state = aep_pkg::ST_SLOPE;
      end
      aep_pkg::ST_SLOPE: begin
        next_st.cu[st.k] = aep_pkg::CW'(aep_pkg::mule(aep_pkg::EW'(st.cu[st.k]), aep_pkg::CU_KEEP))
                         + aep_pkg::CW'(aep_pkg::mule(aep_pkg::EW'(upper_spread_gain), aep_pkg::CU_NEW));
        next_st.d1 = $signed(st.wre[st.k]);
        next_st.d2 = $signed(st.wim[st.k]);
        next_st.j = st.k + 6'd1;
        if (st.k == 6'd39) begin
          // Downward pass only after all upward
          next_st.k = '0;
          next_st.d1 = '0;
          next_st.d2 = '0;
          next_st.state = aep_pkg::ST_DOWN;
        end else begin
          next_st.state = aep_pkg::ST_UP;
        end
      end
      aep_pkg::ST_UP: begin
        n1 = aep_pkg::mulc(st.d1, st.cu[st.k]);
        n2 = aep_pkg::mulc(st.d2, st.cu[st.k]);
        next_st.d1 = n1;
        next_st.d2 = n2;
        next_st.are[st.j] = $signed(st.are[st.j]) + n1;
        next_st.aim[st.j] = $signed(st.aim[st.j]) + n2;
        if (st.j == 6'd39) begin
          next_st.k = st.k + 6'd1;
          next_st.state = aep_pkg::ST_LEVEL;
        end else begin
          next_st.j = st.j + 6'd1;
        end
      end
      aep_pkg::ST_DOWN: begin
        n1 = aep_pkg::mulc(st.d1, aep_pkg::LO_GAIN) + $signed(st.are[st.k]);
        n2 = aep_pkg::mulc(st.d2, aep_pkg::LO_GAIN) + $signed(st.aim[st.k]);
        next_st.d1 = n1;
        next_st.d2 = n2;
        next_st.are[st.k] = n1;
        next_st.aim[st.k] = n2;
        if (st.k == 6'd39) begin
          next_st.k = '0;
          next_st.state = aep_pkg::ST_BAND;
        end else begin
          next_st.k = st.k + 6'd1;
        end
      end
      aep_pkg::ST_BAND: begin
        e0 = aep_pkg::energy($signed(st.are[st.k]), $signed(st.aim[st.k]));
        // Each frame feeds two overlapping windows
        ta = 4'd5 - 4'(st.ph);
        tb = 4'd11 - 4'(st.ph);
        sa = st.acc_a[st.k] + aep_pkg::mule(e0, aep_pkg::TAP[ta]);
        sb = st.acc_b[st.k] + aep_pkg::mule(e0, aep_pkg::TAP[tb]);
        if (st.ph == 3'(aep_pkg::DECIM - 1)) begin
          e2 = sa + aep_pkg::NOISE[st.k];
          next_st.fm[st.k] = aep_pkg::mule(st.fm[st.k], aep_pkg::FM_KEEP[st.k])
                           + aep_pkg::mule(e2, aep_pkg::FM_NEW[st.k]);
          next_st.acc_a[st.k] = sb;
          next_st.acc_b[st.k] = '0;
          next_st.out_valid = 1'b1;
          next_st.out.band = st.k;
          next_st.out.index = st.frame;
          next_st.out.unsmeared = e2;
          next_st.out.excitation = aep_pkg::mule(st.fm[st.k], aep_pkg::FM_KEEP[st.k])
                                 + aep_pkg::mule(e2, aep_pkg::FM_NEW[st.k]);
        end else begin
          next_st.acc_a[st.k] = sa;
          next_st.acc_b[st.k] = sb;
        end
        if (st.k == 6'd39) begin
          next_st.k = '0;
          next_st.ready = 1'b1;
          next_st.state = aep_pkg::ST_LOAD;
          if (st.ph == 3'(aep_pkg::DECIM - 1)) begin
            next_st.ph = '0;
            next_st.frame = st.frame + 16'h0001;
          end else begin
            next_st.ph = st.ph + 3'h1;
          end
        end else begin
          next_st.k = st.k + 6'd1;
        end
      end
      default: begin
        next_st.state = aep_pkg::ST_LOAD;
        next_st.k = '0;
      end
    endcase
    if (MEAS_START) begin
      next_st = '0;
      next_st.ready = 1'b1;
    end
  end

  // State register; reset leaves input closed for one cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// *** tb/aep_excitation_pipeline_checker.sv ***
`timescale 1ns/100ps
module aep_excitation_pipeline_checker (
  input wire logic             CLOCK,
  input wire logic             RST_N,
  input wire logic             MEAS_START,
  input wire logic             IN_VALID,
  input aep_pkg::aep_band_in_t IN_SAMPLE,
  input wire logic             IN_READY,
  input wire logic             OUT_VALID,
  input aep_pkg::aep_pattern_t OUT_PATTERN
);
  logic [5:0]  beat;
  logic [15:0] frames;
  logic [15:0] bursts;
  wire         take = IN_VALID && IN_READY;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // Beats, frames and bursts since start
  always_ff @(posedge CLOCK) begin
    if (!RST_N || MEAS_START) begin
      beat   <= 6'h00;
      frames <= 16'h0000;
      bursts <= 16'h0000;
    end else begin
      if (take) begin
        beat   <= (beat == 6'h27) ? 6'h00 : beat + 6'h01;
        frames <= frames + ((beat == 6'h27) ? 16'h0001 : 16'h0000);
      end
      if (OUT_VALID && OUT_PATTERN.band == 6'h27) begin
        bursts <= bursts + 16'h0001;
      end
    end
  end
  a_start_clears: assert property (MEAS_START |=> IN_READY && !OUT_VALID)
    else $error("start did not reopen input");
  a_ready_drop: assert property (take && beat == 6'h27 |=> !IN_READY)
    else $error("input open after last band");
  a_ready_holds: assert property (IN_READY && !(take && beat == 6'h27) |=> IN_READY)
    else $error("input closed mid frame");
  a_burst_first: assert property ($rose(OUT_VALID) |-> OUT_PATTERN.band == 6'h00)
    else $error("burst not starting at band 0");
  a_band_order: assert property (OUT_VALID && $past(OUT_VALID) |-> OUT_PATTERN.band == $past(OUT_PATTERN.band) + 6'h01)
    else $error("bands out of order");
  a_burst_len: assert property ($fell(OUT_VALID) |-> $past(OUT_PATTERN.band) == 6'h27)
    else $error("burst ended early");
  a_six_frames: assert property ($rose(OUT_VALID) |-> frames == bursts * 16'h0006 + 16'h0006)
    else $error("pattern not on sixth frame");
  a_index_count: assert property (OUT_VALID |-> OUT_PATTERN.index == bursts)
    else $error("pattern index wrong");
  a_noise_floor: assert property (OUT_VALID |-> OUT_PATTERN.unsmeared >= aep_pkg::NOISE[OUT_PATTERN.band])
    else $error("energy below internal noise");
  a_pattern_hold: assert property (!OUT_VALID && $past(RST_N) && !$past(MEAS_START) |-> $stable(OUT_PATTERN))
    else $error("pattern changed between beats");
  c_burst: cover property ($rose(OUT_VALID));
  c_start: cover property (MEAS_START);
  c_stall: cover property (IN_READY && !IN_VALID ##1 IN_VALID);
endmodule
bind aep_excitation_pipeline aep_excitation_pipeline_checker u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .MEAS_START(MEAS_START), .IN_VALID(IN_VALID), .IN_SAMPLE(IN_SAMPLE), .IN_READY(IN_READY),
  .OUT_VALID(OUT_VALID), .OUT_PATTERN(OUT_PATTERN));

// *** tb/aep_bank_model.sv ***
`timescale 1ns/100ps
module aep_bank_model (
  input  wire logic                         clock,
  input  wire logic                         go,
  input  wire logic                         slow,
  input  wire logic [aep_pkg::NB-1:0][47:0] frame,
  input  wire logic                         ready,
  output logic                              valid,
  output aep_pkg::aep_band_in_t             sample,
  output logic                              busy
);
  int w;
  initial begin
    valid = 1'b0;
    sample = '0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy = 1'b1;
        for (int k = 0; k < aep_pkg::NB; k++) begin
          // Stalls invert the data each cycle, so two stall cycles show the stale band again
          repeat (slow ? $urandom_range(3) : 0) begin
            #1 valid = 1'b0;
            sample = ~sample;
            @(posedge clock);
          end
          #1 valid = 1'b1;
          sample = aep_pkg::aep_band_in_t'(frame[k]);
          w = 0;
          @(posedge clock);
          while (!ready && w < 4000) begin
            w++;
            @(posedge clock);
          end
        end
        #1 valid = 1'b0;
        sample = ~sample;
        busy = 1'b0;
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  // Frame spacing shortened from the full hop to keep the run short
  localparam int FRAME_CYC = 1500;
  logic                         CLOCK = 1'b0;
  logic                         RST_N = 1'b0;
  logic                         MEAS_START = 1'b0;
  logic                         IN_VALID;
  logic                         IN_READY;
  logic                         OUT_VALID;
  aep_pkg::aep_band_in_t        IN_SAMPLE;
  aep_pkg::aep_pattern_t        OUT_PATTERN;
  logic [aep_pkg::NB-1:0][47:0] frame = '0;
  logic                         go = 1'b0;
  logic                         slow = 1'b0;
  logic                         busy;
  logic                         quiet = 1'b0;
  logic                         hung = 1'b0;
  int                           fails = 0;
  int                           n_tests = 0;
  int                           oidx = 0;
  int                           oband = 0;
  real                          hist[$];
  real                          prev[aep_pkg::NB];

  always #50 CLOCK = ~CLOCK;

  aep_excitation_pipeline u_aep_excitation_pipeline (.CLOCK(CLOCK), .RST_N(RST_N), .MEAS_START(MEAS_START),
    .IN_VALID(IN_VALID), .IN_SAMPLE(IN_SAMPLE), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
    .OUT_PATTERN(OUT_PATTERN));
  aep_bank_model u_aep_bank_model (.clock(CLOCK), .go(go), .slow(slow), .frame(frame), .ready(IN_READY),
    .valid(IN_VALID), .sample(IN_SAMPLE), .busy(busy));

  // Expected figures worked out in floating point
  function automatic real fk(int k);
    return aep_pkg::FC_HZ[k] / 1000.0;
  endfunction
  function automatic real noise(int k);
    return $pow(10.0, 0.4 * 0.364 * $pow(fk(k), -0.8)) * 8388608.0;
  endfunction
  function automatic real keep(int k);
    return $exp(-192.0 / (48000.0 * (0.004 + 0.1 / fk(k) * 0.016)));
  endfunction
  function automatic real gain0();
    real f;
    f = fk(0);
    return $pow(10.0, (-2.184 * $pow(f, -0.8) + 6.5 * $exp(-0.6 * (f - 3.3) ** 2) - 0.001 * $pow(f, 3.6)) / 20.0);
  endfunction
  function automatic real sq(logic signed [23:0] v);
    return real'(v) * real'(v);
  endfunction

  task automatic complete_run();
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_bits(string nm, logic [47:0] exp, logic [47:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic chk_near(string nm, real exp, logic [47:0] seen, real tol);
    real d;
    n_tests++;
    d = real'(seen) - exp;
    if ((^seen === 1'bx) || d > tol || d < -tol) begin
      fails++;
      $display("FAIL %s expected %0.1f seen %0d", nm, exp, seen);
    end
  endtask

  // Band 0 sees no spreading, so its energy is known exactly
  task automatic beat_check();
    real un;
    real e;
    real a;
    un = real'(OUT_PATTERN.unsmeared);
    a = keep(oband);
    e = 0.0;
    for (int i = 0; i < 12 && i < hist.size(); i++) begin
      e += hist[i] * 0.9761 / 6.0 * $cos(3.14159265358979 * (i - 5) / 12.0) ** 2;
    end
    chk_bits("band", 48'(oband), 48'(OUT_PATTERN.band));
    chk_bits("index", 48'(oidx), 48'(OUT_PATTERN.index));
    if (oband == 0) begin
      chk_near("band0", noise(0) + e, OUT_PATTERN.unsmeared, 4.0 + 0.02 * e);
    end else if (quiet) begin
      chk_near("floor", noise(oband), OUT_PATTERN.unsmeared, 4.0);
    end else begin
      chk_bits("above", 48'h1, 48'(un > noise(oband) - 4.0));
    end
    prev[oband] = a * prev[oband] + (1.0 - a) * un;
    chk_near("excite", prev[oband], OUT_PATTERN.excitation, 4.0 + 1.0E-4 * un);
    oband = (oband == 39) ? 0 : oband + 1;
    if (oband == 0) oidx++;
  endtask

  // Output beats checked mid-cycle, where they are settled
  always @(negedge CLOCK) begin
    if (OUT_VALID === 1'b1) begin
      beat_check();
    end
  end

  task automatic run_seg(int seg, int n);
    int w;
    logic [47:0] b0;
    for (int f = 0; f < n && !hung; f++) begin
      quiet = (seg == 1 && f < 6);
      slow = 1'($urandom_range(1));
      for (int k = 0; k < aep_pkg::NB; k++) begin
        frame[k] = quiet ? 48'h0 : 48'({$urandom, $urandom});
      end
      // Full-scale corner pair on the lowest band
      if (seg == 0 && f == 1) frame[0] = {24'h7FFFFF, 24'h800000};
      b0 = frame[0];
      hist.push_front(gain0() ** 2 * (sq(b0[47:24]) + sq(b0[23:0])) / 8388608.0);
      @(posedge CLOCK);
      #1 go = 1'b1;
      @(posedge CLOCK);
      #1 go = 1'b0;
      w = 0;
      while (busy !== 1'b0 && w < 4000) begin
        w++;
        @(posedge CLOCK);
      end
      // A hung frame ends the stimulus; the verdict follows in one place
      if (w == 4000) begin
        fails++;
        hung = 1'b1;
      end else begin
        repeat (FRAME_CYC) @(posedge CLOCK);
      end
    end
  endtask

  initial begin
    void'($urandom(32'h73a2));
    repeat (4) @(posedge CLOCK);
    #1 RST_N = 1'b1;
    repeat (2) @(posedge CLOCK);
    run_seg(0, 13);
    chk_bits("bursts", 48'h2, 48'(oidx));
    // Restart mid-run, then quiet frames expose stale state
    @(posedge CLOCK);
    #1 MEAS_START = 1'b1;
    hist.delete();
    foreach (prev[k]) prev[k] = 0.0;
    oidx = 0;
    @(posedge CLOCK);
    #1 MEAS_START = 1'b0;
    chk_bits("ready", 48'h1, 48'(IN_READY));
    chk_bits("cleared", 48'h0, OUT_PATTERN.excitation);
    run_seg(1, 12);
    chk_bits("bursts", 48'h2, 48'(oidx));
    complete_run();
  end
endmodule
